// File: logic/pms_master.sv
`timescale 1ns/1ns
module pms_master
    import pms_pkg::*;
(
    input wire logic clk, // system clock, 20 MHz
    input wire logic nrst, // async reset, active low
    input wire logic wbCyc, // wishbone cycle
    input wire logic wbStb, // wishbone strobe
    input wire logic wbWe, // wishbone write enable
    input wire logic [7:0] wbAdr, // wishbone byte address
    input wire logic [3:0] wbSel, // wishbone byte selects
    input wire logic [31:0] wbDatW, // wishbone write data
    output logic [31:0] wbDatR, // wishbone read data
    output logic wbAck, // wishbone acknowledge
    output logic mdc, // management clock to the PHY
    output logic mdioOut, // data line drive value
    output logic mdioOe, // data line drive enable
    input wire logic mdioIn // data line level
);
    pms_ctrl_t ctrl_reg;
    logic [15:0] data_reg;
    logic ack_reg;
    logic [31:0] datR_reg;
    pms_state_t state_reg;
    logic [63:0] txShift_reg;
    logic [15:0] rxShift_reg;
    logic [5:0] bitIdx_reg;
    logic isWrite_reg;
    logic oe_reg;
    logic riseDly_reg;
    logic [2:0] range_reg;
    logic [4:0] phy_reg;
    logic riseTick;
    logic fallTick;
    logic mdcInt;
    logic take;
    logic [31:0] mask;
    logic [31:0] ctrlMerged;
    logic [31:0] dataMerged;
    logic [1:0] opCode;

    // one bus request is taken in the cycle before ack
    assign take = wbCyc && wbStb && !ack_reg;
    assign mask = {{8{wbSel[3]}}, {8{wbSel[2]}}, {8{wbSel[1]}}, {8{wbSel[0]}}};
    assign ctrlMerged = ({16'h0000, ctrl_reg} & ~mask) | (wbDatW & mask);
    assign dataMerged = ({16'h0000, data_reg} & ~mask) | (wbDatW & mask);

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= take;
        end
    end

    // read data, unmapped addresses read as zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            datR_reg <= 32'h00000000;
        end else if (take && !wbWe) begin
            if (wbAdr == ADR_CTRL) begin
                datR_reg <= {16'h0000, ctrl_reg};
            end else if (wbAdr == ADR_DATA) begin
                datR_reg <= {16'h0000, data_reg};
            end else begin
                datR_reg <= 32'h00000000;
            end
        end
    end

    assign wbAck = ack_reg;
    assign wbDatR = datR_reg;

    // control register: writes ignored while busy, busy cleared at frame end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= CTRL_RESET;
        end else if (state_reg == ST_END && fallTick) begin
            ctrl_reg.mgmtBusy <= 1'b0;
        end else if (take && wbWe && wbAdr == ADR_CTRL && !ctrl_reg.mgmtBusy) begin
            ctrl_reg <= ctrlMerged[15:0];
            ctrl_reg.rsvd <= 1'b0;
        end
    end

    // data register: software value for writes, PHY value after reads
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_reg <= DATA_RESET;
        end else if (state_reg == ST_END && fallTick && !isWrite_reg) begin
            data_reg <= rxShift_reg;
        end else if (take && wbWe && wbAdr == ADR_DATA && !ctrl_reg.mgmtBusy) begin
            data_reg <= dataMerged[15:0];
        end
    end

    // frame sequencer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (ctrl_reg.mgmtBusy) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (riseTick && bitIdx_reg == IDX_LAST) begin
                        state_reg <= ST_END;
                    end
                end
                ST_END: begin
                    if (fallTick) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign opCode = ctrl_reg.mgmtWriteSelect ? OP_WRITE : OP_READ;

    // outgoing bit stream, changed one cycle after each rising edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            txShift_reg <= 64'h0000000000000000;
            bitIdx_reg <= 6'h00;
            isWrite_reg <= 1'b0;
            range_reg <= RANGE_DIV42;
            phy_reg <= 5'h00;
        end else if (state_reg == ST_IDLE && ctrl_reg.mgmtBusy) begin
            txShift_reg <= {PREAMBLE, START_PAT, opCode, ctrl_reg.phyAddr,
                ctrl_reg.regIndexField, TA_WRITE,
                ctrl_reg.mgmtWriteSelect ? data_reg : 16'h0000};
            bitIdx_reg <= 6'h00;
            isWrite_reg <= ctrl_reg.mgmtWriteSelect;
            range_reg <= ctrl_reg.clockRangeSelect;
            phy_reg <= ctrl_reg.phyAddr;
        end else if (state_reg == ST_RUN && riseDly_reg) begin
            txShift_reg <= {txShift_reg[62:0], 1'b1};
            bitIdx_reg <= bitIdx_reg + 6'h01;
        end
    end

    // drive enable: released on read turnaround and data, and when idle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oe_reg <= 1'b0;
        end else if (state_reg == ST_IDLE && ctrl_reg.mgmtBusy) begin
            oe_reg <= 1'b1;
        end else if (state_reg == ST_RUN && riseDly_reg) begin
            oe_reg <= isWrite_reg || (bitIdx_reg + 6'h01 < IDX_TA);
        end else if (state_reg == ST_END && fallTick) begin
            oe_reg <= 1'b0;
        end
    end

    // rising edge marker delayed one cycle for the output change
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            riseDly_reg <= 1'b0;
        end else begin
            riseDly_reg <= riseTick && state_reg == ST_RUN;
        end
    end

    // read data sampled at the rising edge of each data bit
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxShift_reg <= 16'h0000;
        end else if (state_reg == ST_RUN && riseTick && bitIdx_reg >= IDX_DATA) begin
            rxShift_reg <= {rxShift_reg[14:0], mdioIn};
        end
    end

    assign mdioOut = txShift_reg[63];
    assign mdioOe = oe_reg;
    assign mdc = mdcInt;

    pms_mdc_gen pms_mdc_gen_inst (
        .clk(clk),
        .nrst(nrst),
        .run(state_reg != ST_IDLE),
        .rangeSel(range_reg),
        .mdc(mdcInt),
        .riseTick(riseTick),
        .fallTick(fallTick)
    );

    a_idle_clock_low: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == ST_IDLE) |-> !mdcInt)
        else $error("mdc not low while idle");
    a_idle_line_free: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == ST_IDLE) |-> !mdioOe)
        else $error("data line driven while idle");
    a_preamble_ones: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == ST_RUN && bitIdx_reg < IDX_START) |-> (mdioOe && mdioOut))
        else $error("preamble bit not one");
    a_start_bits: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == ST_RUN && bitIdx_reg == IDX_START) |-> (mdioOe && !mdioOut))
        else $error("start pattern first bit not zero");
    a_opcode_bit: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == ST_RUN && bitIdx_reg == IDX_OP) |-> (mdioOut == !isWrite_reg))
        else $error("opcode first bit wrong");
    a_phy_msb: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == ST_RUN && bitIdx_reg == IDX_PHY) |-> (mdioOut == phy_reg[4]))
        else $error("phy address msb not first");
    a_read_ta_free: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == ST_RUN && !isWrite_reg && bitIdx_reg >= IDX_TA) |-> !mdioOe)
        else $error("line driven in read turnaround or data");
    a_write_ta_bits: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == ST_RUN && isWrite_reg && bitIdx_reg == IDX_TA && riseDly_reg)
        |-> (mdioOe && mdioOut) ##1 (mdioOe && !mdioOut))
        else $error("write turnaround not driven as 10");
    a_busy_clears: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == ST_END && fallTick) |=> (!ctrl_reg.mgmtBusy && state_reg == ST_IDLE))
        else $error("busy not cleared at frame end");
    a_read_loads: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == ST_END && fallTick && !isWrite_reg) |=> (data_reg == $past(rxShift_reg)))
        else $error("read data not loaded");
    a_change_after_rise: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == ST_RUN && $changed(mdioOut)) |-> $past(riseTick, 2) || $past(state_reg) == ST_IDLE)
        else $error("data changed away from a rising edge");

    c_write_frame: cover property (@(posedge clk) disable iff (!nrst)
        state_reg == ST_END && fallTick && isWrite_reg);
    c_read_frame: cover property (@(posedge clk) disable iff (!nrst)
        state_reg == ST_END && fallTick && !isWrite_reg);
    c_write_while_busy: cover property (@(posedge clk) disable iff (!nrst)
        take && wbWe && ctrl_reg.mgmtBusy);
    c_unmapped_read: cover property (@(posedge clk) disable iff (!nrst)
        take && !wbWe && wbAdr != ADR_CTRL && wbAdr != ADR_DATA);
endmodule : pms_master

// File: include/pms_pkg.sv
// Operation
// - one register of one of 32 PHYs per operation
// - management clock held low while idle
// - clock at most 2.5MHz, phases at least 160ns
// - frame opens with 32 preamble ones
// - start pattern 01 follows the preamble
// - five-bit PHY address, MSB first
// - five-bit register index, MSB first
// - read turnaround: master releases both bits
// - write turnaround: master drives 10
// - sixteen data bits, bit 15 first
// - data line released between operations
// - clock divider chosen by clock range code
// - busy with write-select runs write, clears busy
// - busy alone runs read, loads data, clears busy
package pms_pkg;
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int MDC_MAX_HZ = 2_500_000;
    localparam int MDC_MIN_HALF_NS = 160;
    localparam int MDC_MIN_PERIOD_NS = 400;
    localparam int MIN_HALF_CYC = (MDC_MIN_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_PERIOD_CYC = (MDC_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_DIV = (CLK_HZ + MDC_MAX_HZ - 1) / MDC_MAX_HZ;
    // clock range codes and half-period counts
    localparam logic [2:0] RANGE_DIV42 = 3'h0;
    localparam logic [2:0] RANGE_DIV62 = 3'h1;
    localparam logic [2:0] RANGE_DIV16 = 3'h2;
    localparam logic [2:0] RANGE_DIV26 = 3'h3;
    localparam logic [2:0] RANGE_DIV102 = 3'h4;
    localparam logic [5:0] HALF_DIV42 = 6'h15;
    localparam logic [5:0] HALF_DIV62 = 6'h1F;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV26 = 6'h0D;
    localparam logic [5:0] HALF_DIV102 = 6'h33;
    // register map
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_DATA = 8'h04;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    // frame layout, bit positions counted from the first preamble bit
    localparam logic [5:0] IDX_START = 6'h20;
    localparam logic [5:0] IDX_OP = 6'h22;
    localparam logic [5:0] IDX_PHY = 6'h24;
    localparam logic [5:0] IDX_REG = 6'h29;
    localparam logic [5:0] IDX_TA = 6'h2E;
    localparam logic [5:0] IDX_DATA = 6'h30;
    localparam logic [5:0] IDX_LAST = 6'h3F;
    localparam logic [31:0] PREAMBLE = 32'hFFFFFFFF;
    localparam logic [1:0] START_PAT = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] TA_WRITE = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_END = 2'b10
    } pms_state_t;

    // control register layout
    typedef struct packed {
        logic [4:0] phyAddr;
        logic [4:0] regIndexField;
        logic rsvd;
        logic [2:0] clockRangeSelect;
        logic mgmtWriteSelect;
        logic mgmtBusy;
    } pms_ctrl_t;
endpackage : pms_pkg

// File: logic/pms_mdc_gen.sv
`timescale 1ns/1ns
module pms_mdc_gen
    import pms_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic run, // frame in progress
    input wire logic [2:0] rangeSel, // clock range code
    output logic mdc, // management clock
    output logic riseTick, // mdc rises at this edge
    output logic fallTick // mdc falls at this edge
);
    logic [5:0] half;
    logic [5:0] cnt_reg;
    logic mdc_reg;
    logic [6:0] hiLen_reg;

    // half period per range code, reserved codes take the slowest
    always_comb begin
        unique case (rangeSel)
            RANGE_DIV42: half = HALF_DIV42;
            RANGE_DIV62: half = HALF_DIV62;
            RANGE_DIV16: half = HALF_DIV16;
            RANGE_DIV26: half = HALF_DIV26;
            RANGE_DIV102: half = HALF_DIV102;
            default: half = HALF_DIV102;
        endcase
    end

    // phase counter, parked at zero while idle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 6'h00;
        end else if (!run || cnt_reg == half - 6'h01) begin
            cnt_reg <= 6'h00;
        end else begin
            cnt_reg <= cnt_reg + 6'h01;
        end
    end

    // clock level, low whenever no frame runs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mdc_reg <= 1'b0;
        end else if (!run) begin
            mdc_reg <= 1'b0;
        end else if (cnt_reg == half - 6'h01) begin
            mdc_reg <= ~mdc_reg;
        end
    end

    assign mdc = mdc_reg;
    assign riseTick = run && cnt_reg == half - 6'h01 && !mdc_reg;
    assign fallTick = run && cnt_reg == half - 6'h01 && mdc_reg;

    // high phase length, checked against the divider
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hiLen_reg <= 7'h00;
        end else if (!mdc_reg) begin
            hiLen_reg <= 7'h00;
        end else begin
            hiLen_reg <= hiLen_reg + 7'h01;
        end
    end

    a_high_phase_min: assert property (@(posedge clk) disable iff (!nrst)
        $rose(mdc_reg) |-> mdc_reg [*4])
        else $error("mdc high phase too short");
    a_low_phase_min: assert property (@(posedge clk) disable iff (!nrst)
        $fell(mdc_reg) |-> !mdc_reg [*4])
        else $error("mdc low phase too short");
    a_div_exact: assert property (@(posedge clk) disable iff (!nrst)
        ($fell(mdc_reg) && $past(run) && run) |-> hiLen_reg == {1'b0, half})
        else $error("mdc high phase does not match range code");
endmodule : pms_mdc_gen

// File: verif/pms_phy_model.sv
`timescale 1ns/1ns
// behavioural PHY management port; the line has a pull-up in the bench
module pms_phy_model
    import pms_pkg::*;
(
    input wire logic nrst, // reset, active low
    input wire logic mdc, // management clock
    input wire logic mdioLine, // resolved data line
    input wire logic [15:0] rdData, // value returned by reads
    output logic phyOe, // PHY drives the line
    output logic phyOut, // PHY drive value
    output logic [63:0] frameBits, // last frame as seen on the line
    output logic [7:0] frames // completed frames
);
    logic [62:0] shiftReg;
    logic [5:0] bitCnt;
    logic isRead;
    int nxt;
    // sample on the rising edge, change the driven bit just after it
    always @(posedge mdc or negedge nrst) begin
        if (!nrst) begin
            shiftReg <= '0;
            bitCnt <= '0;
            isRead <= 1'b0;
            phyOe <= 1'b0;
            phyOut <= 1'b0;
            frameBits <= '0;
            frames <= '0;
        end else begin
            nxt = int'(bitCnt) + 1;
            shiftReg <= {shiftReg[61:0], mdioLine};
            bitCnt <= bitCnt + 6'h01;
            // opcode 10 marks a read; writes leave the turnaround undriven
            if (bitCnt == 6'h23) isRead <= shiftReg[0] & ~mdioLine;
            // first turnaround bit left alone, second driven low
            if (isRead && nxt == 47) begin
                phyOe <= 1'b1;
                phyOut <= 1'b0;
            end
            if (isRead && nxt >= 48 && nxt <= 63) phyOut <= rdData[63 - nxt];
            if (bitCnt == 6'h3F) begin
                frameBits <= {shiftReg, mdioLine};
                frames <= frames + 8'h01;
                phyOe <= 1'b0;
                isRead <= 1'b0;
            end
        end
    end
endmodule : pms_phy_model

// File: verif/pms_master_tb.sv
`timescale 1ns/1ns
// bench for the management master, wishbone side and link side
module pms_master_tb
    import pms_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b1;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = '0;
    logic [3:0] wbSel = '0;
    logic [31:0] wbDatW = '0;
    logic [31:0] wbDatR;
    logic wbAck, mdc, mdioOut, mdioOe, mdioIn, phyOe, phyOut;
    logic [63:0] frameBits;
    logic [7:0] frames;
    logic [15:0] rdData = '0;
    logic mdcPrev = 1'b0;
    logic clash = 1'b0;
    int n_errors = 0;
    int cmp_count = 0;
    int runLen = 0;
    int hiLen = 0;
    int loLen = 0;

    // fixed 20 MHz system clock, below the 25 MHz floor a host must keep; divide counts still hold
    always #25 clk = ~clk;
    // wire level: master, else PHY, else pull-up
    assign mdioIn = mdioOe ? mdioOut : (phyOe ? phyOut : 1'b1);

    pms_master pms_master_inst (.clk, .nrst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatW, .wbDatR,
        .wbAck, .mdc, .mdioOut, .mdioOe, .mdioIn);
    pms_phy_model pms_phy_model_inst (.nrst, .mdc, .mdioLine(mdioIn), .rdData, .phyOe, .phyOut,
        .frameBits, .frames);

    // phase lengths of the management clock, and drive contention
    always @(posedge clk) begin
        if (mdioOe === 1'b1 && phyOe === 1'b1) clash <= 1'b1;
        if (mdc !== mdcPrev) begin
            if (mdcPrev) hiLen <= runLen;
            else loLen <= runLen;
            runLen <= 1;
            mdcPrev <= mdc;
        end else runLen <= runLen + 1;
    end

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict

    // one classic cycle, held until ack is sampled high
    task wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
        int n;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatW <= dat;
        wbSel <= 4'hF;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        check("ack", 32'(wbAck), 32'h1);
        q = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask : wbXfer

    task rd(input logic [7:0] adr, output logic [31:0] q);
        wbXfer(1'b0, adr, 32'h0, q);
    endtask : rd

    task wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] q;
        wbXfer(1'b1, adr, dat, q);
    endtask : wr

    // poll the control word until busy clears
    task waitIdle(output logic [31:0] q);
        int n;
        n = 0;
        do begin
            rd(ADR_CTRL, q);
            n++;
        end while (q[0] !== 1'b0 && n < 3000);
    endtask : waitIdle

    task checkFrame(input pms_ctrl_t c, input logic [15:0] d);
        check("preamble", frameBits[63:32], 32'hFFFFFFFF);
        check("start", 32'(frameBits[31:30]), 32'h1);
        check("opcode", 32'(frameBits[29:28]), c.mgmtWriteSelect ? 32'h1 : 32'h2);
        check("phy address", 32'(frameBits[27:23]), 32'(c.phyAddr));
        check("reg index", 32'(frameBits[22:18]), 32'(c.regIndexField));
        check("turnaround", 32'(frameBits[17:16]), 32'h2);
        check("data field", 32'(frameBits[15:0]), 32'(d));
        check("mdc idle", 32'(mdc), 32'h0);
        check("line released", 32'(mdioOe), 32'h0);
        check("contention", 32'(clash), 32'h0);
    endtask : checkFrame

    initial begin
        logic [31:0] q;
        logic [15:0] d;
        logic [7:0] f0;
        pms_ctrl_t c;
        // half of the divide factors 42, 62, 16, 26, 102; reserved code 5 runs as 102
        int half[6];
        // reset asserted by an edge so the link model resets as well
        nrst <= 1'b0;
        half = '{21, 31, 8, 13, 51, 51};
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        check("mdc in reset", 32'(mdc), 32'h0);
        rd(ADR_CTRL, q);
        check("ctrl reset", q, 32'(CTRL_RESET));
        rd(ADR_DATA, q);
        check("data reset", q, 32'(DATA_RESET));
        wr(8'h08, 32'hFFFFFFFF);
        rd(8'h08, q);
        check("unmapped", q, 32'h0);
        // one write frame per clock range code
        for (int k = 0; k < 6; k++) begin
            c = '0;
            c.phyAddr = 5'(k * 6 + 1);
            c.regIndexField = 5'(31 - k * 5);
            c.clockRangeSelect = 3'(k);
            c.mgmtWriteSelect = 1'b1;
            c.mgmtBusy = 1'b1;
            d = {4'(k + 8), 12'h5A1};
            f0 = frames;
            wr(ADR_DATA, {16'h0000, d});
            wr(ADR_CTRL, {16'h0000, c});
            if (k == 0) begin
                wr(ADR_DATA, 32'h0000FFFF);
            end
            waitIdle(q);
            check("write done", 32'(q[0]), 32'h0);
            checkFrame(c, d);
            rd(ADR_DATA, q);
            check("data kept", q, {16'h0000, d});
            check("frames", 32'(frames), 32'(f0 + 8'h01));
            check("mdc high", hiLen, half[k]);
            check("mdc low", loLen, half[k]);
            check("min phase", 32'(hiLen * 50 >= 160 && loLen * 50 >= 160), 32'h1);
        end
        // read frames at both field extremes, the first hit by writes while busy
        for (int k = 0; k < 2; k++) begin
            c = '0;
            c.phyAddr = k ? 5'h1F : 5'h00;
            c.regIndexField = k ? 5'h1F : 5'h00;
            c.clockRangeSelect = 3'h2;
            c.mgmtBusy = 1'b1;
            d = k ? 16'h0001 : 16'hC35A;
            rdData <= d;
            wr(ADR_CTRL, {16'h0000, c});
            if (k == 0) begin
                wr(ADR_DATA, 32'h0000FFFF);
                wr(ADR_CTRL, 32'h0000FFFF);
            end
            waitIdle(q);
            c.mgmtBusy = 1'b0;
            check("ctrl after read", q, {16'h0000, c});
            checkFrame(c, d);
            rd(ADR_DATA, q);
            check("read data", q, {16'h0000, d});
        end
        give_verdict();
    end

    // watchdog, well beyond the roughly 25000 cycles the tests need
    initial begin
        #(60000 * 50);
        n_errors++;
        give_verdict();
    end
endmodule : pms_master_tb
